// >>> hw/link_regs_pkg.sv
//
// Purpose: Shared constants and types for the link EEPROM and retry register group
// Assumes: Byte addresses on a 32-bit register port
// Notes: Offsets are byte addresses; every field position lives here
//
package link_regs_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_ROM_ACCESS = 8'h04;
    localparam logic [7:0] ADDR_RETRY_LIMITS = 8'h08;
    localparam logic [7:0] ADDR_SWAP_STORE = 8'h0C;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int ROM_CLEAR_BIT = 31;
    localparam int ROM_GO_BIT = 25;
    localparam int READ_BYTE_LSB = 16;
    localparam int SMALL_ROM_LSB = 0;
    localparam int PHYS_RETRY_LSB = 8;
    localparam int RESP_RETRY_LSB = 4;
    localparam int REQ_RETRY_LSB = 0;
    localparam int RETRY_FIELD_W = 4;
    localparam logic [7:0] SMALL_ROM_RESET = 8'h00;
    localparam logic [7:0] SMALL_ROM_WORD = 8'h28;
    localparam logic [7:0] SMALL_ROM_MIN_VALID = 8'h3A;
    localparam logic [7:0] ROM_ADDR_RESET = 8'h00;
    localparam logic [3:0] RETRY_RESET = 4'h0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0]
    {
        ACK_NONE = 2'b00,
        ACK_DONE = 2'b01,
        ACK_BUSY = 2'b10,
        ACK_DATA_ERR = 2'b11
    } ack_code_t;

    typedef struct packed
    {
        logic start;
        logic ackValid;
        ack_code_t ack;
    } tx_attempt_t;

    typedef struct packed
    {
        logic retry;
        logic finished;
        ack_code_t finalAck;
    } tx_result_t;

    typedef struct packed
    {
        logic req;
        logic [7:0] addr;
    } rom_req_t;

endpackage

// >>> hw/rom_byte_fetch.sv
//
// Purpose: Fetches one byte from the serial identity EEPROM reader
// Assumes: Reader answers each held request with a one-cycle ack and data
// Notes: One fetch at a time; start while busy is ignored
//
`timescale 1ns/100ps
module rom_byte_fetch
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [7:0] byteAddr,
    output link_regs_pkg::rom_req_t romReq,
    input wire logic romAck,
    input wire logic [7:0] romData,
    output logic done,
    output logic [7:0] fetchedByte
);
    import link_regs_pkg::*;

    // ************************************************************
    // Request held until the reader answers
    // ************************************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            romReq <= '0;
        end
        else if (romReq.req && romAck)
        begin
            romReq.req <= 1'b0;
        end
        else if (start && !romReq.req)
        begin
            romReq.req <= 1'b1;
            romReq.addr <= byteAddr;
        end
    end

    // ************************************************************
    // Completion
    // ************************************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            done <= 1'b0;
            fetchedByte <= 8'h00;
        end
        else
        begin
            done <= romReq.req && romAck;
            if (romReq.req && romAck)
            begin
                fetchedByte <= romData;
            end
        end
    end

endmodule // rom_byte_fetch

// >>> hw/tx_retry_unit.sv
//
// Purpose: Counts retries of one transmit unit against a software limit
// Assumes: One packet in flight per unit; acks arrive one at a time
// Notes: Limit is sampled live, so a change applies to the packet in flight
//
`timescale 1ns/100ps
module tx_retry_unit
#(
    parameter int COUNT_W = 4
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [COUNT_W-1:0] retryLimit,
    input link_regs_pkg::tx_attempt_t attempt,
    output link_regs_pkg::tx_result_t result
);
    import link_regs_pkg::*;

    logic [COUNT_W-1:0] used_reg;
    logic active_reg;
    logic backoff;

    if (COUNT_W < 1 || COUNT_W > 8)
    begin : g_bad_width
        $error("tx_retry_unit: COUNT_W out of range");
    end

    assign backoff = attempt.ackValid && (attempt.ack == ACK_BUSY || attempt.ack == ACK_DATA_ERR);

    // ************************************************************
    // Attempt tracking
    // ************************************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            used_reg <= '0;
            active_reg <= 1'b0;
            result <= '0;
        end
        else
        begin
            result.retry <= 1'b0;
            result.finished <= 1'b0;
            if (attempt.start)
            begin
                used_reg <= '0;
                active_reg <= 1'b1;
            end
            else if (active_reg && attempt.ackValid)
            begin
                if (backoff && used_reg < retryLimit)
                begin
                    used_reg <= used_reg + 1'b1;
                    result.retry <= 1'b1;
                end
                else
                begin
                    // Out of retries or success: last ack is the outcome
                    active_reg <= 1'b0;
                    result.finished <= 1'b1;
                    result.finalAck <= attempt.ack;
                end
            end
        end
    end

endmodule // tx_retry_unit

// >>> hw/link_eeprom_retry_regs.sv
//
// Purpose: Link-layer EEPROM access, transmit retry limits and swap data registers
// Assumes: Register port with one-cycle strobes, read data one cycle later
// Notes: EEPROM reached through a byte request/ack reader outside this block
//
// Behaviour
// - Writing one to bit 31 returns the EEPROM byte address to zero and the bit clears itself after.
// - An address clear does not fetch byte zero; the read byte keeps its old value.
// - Writing one to bit 25 reads the addressed byte and the bit clears when the read ends.
// - The fetched byte appears in read-only bits 23 to 16 of the access register.
// - The small ROM offset in bits 7 to 0 resets to 00h and loads from EEPROM word 28h if present.
// - Unused bits of the access and retry registers read as zero.
// - The dual phase seconds and cycles fields always read zero.
// - The physical response unit retries up to the count in bits 11 to 8, reset 0h.
// - The transmit response unit retries up to the count in bits 7 to 4, reset 0h.
// - The transmit request unit retries up to the count in bits 3 to 0, reset 0h.
// - The swap store value at 0Ch is read-only and not reset.
// - The EEPROM present flag is set on detection and the info block load is then started.
//
`timescale 1ns/100ps
module link_eeprom_retry_regs
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output logic [31:0] regRdData,
    input wire logic eepromDetect,
    output link_regs_pkg::rom_req_t romReq,
    input wire logic romAck,
    input wire logic [7:0] romData,
    output logic idEepromPresent,
    output logic busInfoLoadStart,
    output logic smallRomValid,
    input wire logic swapValueLoad,
    input wire logic [31:0] swapValueIn,
    input link_regs_pkg::tx_attempt_t physRespAttempt,
    input link_regs_pkg::tx_attempt_t txRespAttempt,
    input link_regs_pkg::tx_attempt_t txReqAttempt,
    output link_regs_pkg::tx_result_t physRespResult,
    output link_regs_pkg::tx_result_t txRespResult,
    output link_regs_pkg::tx_result_t txReqResult
);
    import link_regs_pkg::*;

    typedef enum logic [1:0]
    {
        ST_STRAP = 2'b00,
        ST_BOOT = 2'b01,
        ST_IDLE = 2'b10,
        ST_READ = 2'b11
    } rom_state_t;

    rom_state_t state_reg;
    logic rom_address_clear_reg;
    logic rom_read_go_reg;
    logic [7:0] rom_read_byte_reg;
    logic [7:0] small_rom_offset_reg;
    logic [7:0] romAddr_reg;
    logic [3:0] phys_response_retry_count_reg;
    logic [3:0] tx_response_retry_count_reg;
    logic [3:0] tx_request_retry_count_reg;
    logic [31:0] swapStore_reg;
    logic fetchStart;
    logic [7:0] fetchAddr;
    logic fetchDone;
    logic [7:0] fetchedByte;
    logic wrAccess;
    logic wrRetry;
    logic [31:0] readMux;

    assign wrAccess = regWrStrobe && regAddr == ADDR_ROM_ACCESS;
    assign wrRetry = regWrStrobe && regAddr == ADDR_RETRY_LIMITS;

    // ************************************************************
    // EEPROM sequencing
    // ************************************************************
    assign fetchStart = (state_reg == ST_BOOT && !romReq.req && !fetchDone)
        || (state_reg == ST_IDLE && rom_read_go_reg && !rom_address_clear_reg);
    assign fetchAddr = (state_reg == ST_BOOT) ? SMALL_ROM_WORD : romAddr_reg;

    rom_byte_fetch fetch
    (
        .clk(clk),
        .resetn(resetn),
        .start(fetchStart),
        .byteAddr(fetchAddr),
        .romReq(romReq),
        .romAck(romAck),
        .romData(romData),
        .done(fetchDone),
        .fetchedByte(fetchedByte)
    );

    // Strap is caught after release, never by the asynchronous reset itself
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= ST_STRAP;
            idEepromPresent <= 1'b0;
            busInfoLoadStart <= 1'b0;
        end
        else
        begin
            busInfoLoadStart <= 1'b0;
            case (state_reg)
                ST_STRAP:
                begin
                    idEepromPresent <= eepromDetect;
                    state_reg <= eepromDetect ? ST_BOOT : ST_IDLE;
                end
                ST_BOOT:
                begin
                    if (fetchDone)
                    begin
                        busInfoLoadStart <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_IDLE:
                begin
                    if (fetchStart)
                    begin
                        state_reg <= ST_READ;
                    end
                end
                ST_READ:
                begin
                    if (fetchDone)
                    begin
                        state_reg <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Boot fetch fills the small ROM offset; no EEPROM leaves the reset value
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            small_rom_offset_reg <= SMALL_ROM_RESET;
        end
        else if (state_reg == ST_BOOT && fetchDone)
        begin
            small_rom_offset_reg <= fetchedByte;
        end
    end

    // Helper only: the decision is software's
    assign smallRomValid = small_rom_offset_reg > SMALL_ROM_MIN_VALID;

    // ************************************************************
    // Access register control bits
    // ************************************************************
    // Clear is served before a pending read so a read never uses a stale address
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rom_address_clear_reg <= 1'b0;
        end
        else if (wrAccess && regWrData[ROM_CLEAR_BIT])
        begin
            rom_address_clear_reg <= 1'b1;
        end
        else if (state_reg == ST_IDLE)
        begin
            rom_address_clear_reg <= 1'b0;
        end
    end

    // Software set wins over completion clear in the same cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rom_read_go_reg <= 1'b0;
        end
        else if (wrAccess && regWrData[ROM_GO_BIT])
        begin
            rom_read_go_reg <= 1'b1;
        end
        else if (state_reg == ST_READ && fetchDone)
        begin
            rom_read_go_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            romAddr_reg <= ROM_ADDR_RESET;
        end
        else if (state_reg == ST_IDLE && rom_address_clear_reg)
        begin
            romAddr_reg <= ROM_ADDR_RESET;
        end
        else if (state_reg == ST_READ && fetchDone)
        begin
            romAddr_reg <= romAddr_reg + 8'h01;
        end
    end

    // Only an explicit read updates the byte; a clear leaves it alone
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rom_read_byte_reg <= 8'h00;
        end
        else if (state_reg == ST_READ && fetchDone)
        begin
            rom_read_byte_reg <= fetchedByte;
        end
    end

    // ************************************************************
    // Retry limits
    // ************************************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            phys_response_retry_count_reg <= RETRY_RESET;
            tx_response_retry_count_reg <= RETRY_RESET;
            tx_request_retry_count_reg <= RETRY_RESET;
        end
        else if (wrRetry)
        begin
            phys_response_retry_count_reg <= regWrData[PHYS_RETRY_LSB +: RETRY_FIELD_W];
            tx_response_retry_count_reg <= regWrData[RESP_RETRY_LSB +: RETRY_FIELD_W];
            tx_request_retry_count_reg <= regWrData[REQ_RETRY_LSB +: RETRY_FIELD_W];
        end
    end

    tx_retry_unit #(.COUNT_W(RETRY_FIELD_W)) physResp
    (
        .clk(clk),
        .resetn(resetn),
        .retryLimit(phys_response_retry_count_reg),
        .attempt(physRespAttempt),
        .result(physRespResult)
    );

    tx_retry_unit #(.COUNT_W(RETRY_FIELD_W)) txResp
    (
        .clk(clk),
        .resetn(resetn),
        .retryLimit(tx_response_retry_count_reg),
        .attempt(txRespAttempt),
        .result(txRespResult)
    );

    tx_retry_unit #(.COUNT_W(RETRY_FIELD_W)) txReq
    (
        .clk(clk),
        .resetn(resetn),
        .retryLimit(tx_request_retry_count_reg),
        .attempt(txReqAttempt),
        .result(txReqResult)
    );

    // ************************************************************
    // Swap store value
    // ************************************************************
    // Deliberately unreset: contents are undefined until the swap logic loads it
    always_ff @(posedge clk)
    begin
        if (swapValueLoad)
        begin
            swapStore_reg <= swapValueIn;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb
    begin
        readMux = READ_ZERO;
        if (regAddr == ADDR_ROM_ACCESS)
        begin
            readMux[ROM_CLEAR_BIT] = rom_address_clear_reg;
            readMux[ROM_GO_BIT] = rom_read_go_reg;
            readMux[READ_BYTE_LSB +: 8] = rom_read_byte_reg;
            readMux[SMALL_ROM_LSB +: 8] = small_rom_offset_reg;
        end
        else if (regAddr == ADDR_RETRY_LIMITS)
        begin
            readMux[PHYS_RETRY_LSB +: RETRY_FIELD_W] = phys_response_retry_count_reg;
            readMux[RESP_RETRY_LSB +: RETRY_FIELD_W] = tx_response_retry_count_reg;
            readMux[REQ_RETRY_LSB +: RETRY_FIELD_W] = tx_request_retry_count_reg;
        end
        else if (regAddr == ADDR_SWAP_STORE)
        begin
            readMux = swapStore_reg;
        end
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            regRdData <= READ_ZERO;
        end
        else if (regRdStrobe)
        begin
            regRdData <= readMux;
        end
        else
        begin
            regRdData <= READ_ZERO;
        end
    end

endmodule // link_eeprom_retry_regs

// >>> testbench/link_regs_sva.sv
//
// Purpose: Port-level assertions for the link EEPROM and retry register group
// Assumes: One clock domain, reset active low
// Notes: Bound to the top module below
//
`timescale 1ns/100ps
module link_regs_sva
    import link_regs_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] regAddr,
    input wire logic regRdStrobe,
    input wire logic [31:0] regRdData,
    input link_regs_pkg::rom_req_t romReq,
    input wire logic romAck,
    input wire logic eepromDetect,
    input wire logic idEepromPresent,
    input wire logic busInfoLoadStart,
    input link_regs_pkg::tx_attempt_t txReqAttempt,
    input link_regs_pkg::tx_result_t txReqResult,
    input link_regs_pkg::tx_attempt_t physRespAttempt,
    input link_regs_pkg::tx_result_t physRespResult
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_rd_idle_zero: assert property (!$past(regRdStrobe) |-> regRdData == 32'h0)
        else $error("read data not zero outside read cycle");
    chk_retry_hi_zero: assert property ($past(regRdStrobe) && $past(regAddr) == ADDR_RETRY_LIMITS
        |-> regRdData[31:12] == 20'h0)
        else $error("retry register upper bits not zero");
    chk_access_rsvd: assert property ($past(regRdStrobe) && $past(regAddr) == ADDR_ROM_ACCESS
        |-> regRdData[30:26] == 5'h0 && !regRdData[24] && regRdData[15:8] == 8'h0)
        else $error("access register reserved bits not zero");
    chk_req_hold: assert property (romReq.req && !romAck |=> romReq.req && $stable(romReq.addr))
        else $error("byte request dropped or moved before answer");
    chk_req_drop: assert property (romReq.req && romAck |=> !romReq.req)
        else $error("byte request held after answer");
    chk_boot_fetch: assert property ($rose(idEepromPresent)
        |-> ##[0:2] romReq.req && romReq.addr == SMALL_ROM_WORD)
        else $error("boot fetch of offset word missing");
    chk_strap_cause: assert property ($rose(idEepromPresent) |-> $past(eepromDetect))
        else $error("present flag without strap");
    chk_info_pulse: assert property (busInfoLoadStart |=> !busInfoLoadStart)
        else $error("info load start longer than one cycle");
    chk_req_retry: assert property (txReqResult.retry
        |-> $past(txReqAttempt.ackValid) && $past(txReqAttempt.ack[1]))
        else $error("request retry without busy or error ack");
    chk_phys_retry: assert property (physRespResult.retry
        |-> $past(physRespAttempt.ackValid) && $past(physRespAttempt.ack[1]))
        else $error("physical retry without busy or error ack");
    chk_final_ack: assert property (txReqResult.finished
        |-> $past(txReqAttempt.ackValid) && txReqResult.finalAck == $past(txReqAttempt.ack))
        else $error("final ack differs from last ack");
endmodule // link_regs_sva

bind link_eeprom_retry_regs link_regs_sva u_chk (.clk(clk), .resetn(resetn), .regAddr(regAddr),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData), .romReq(romReq), .romAck(romAck),
    .eepromDetect(eepromDetect), .idEepromPresent(idEepromPresent),
    .busInfoLoadStart(busInfoLoadStart), .txReqAttempt(txReqAttempt),
    .txReqResult(txReqResult), .physRespAttempt(physRespAttempt),
    .physRespResult(physRespResult));

// >>> testbench/eeprom_reader_model.sv
//
// Purpose: Behavioural EEPROM byte reader behind the request/ack port
// Assumes: One request at a time, held until answered
// Notes: Data line toggles when idle so a stale byte is never seen
//
`timescale 1ns/100ps
module eeprom_reader_model
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input link_regs_pkg::rom_req_t romReq,
    output logic romAck,
    output logic [7:0] romData
);
    import link_regs_pkg::*;
    logic [3:0] waitCnt;
    logic served;

    // Offset word holds a value above 3Ah, a usable small ROM
    function automatic logic [7:0] romByte(input logic [7:0] a);
        return (a == SMALL_ROM_WORD) ? 8'h4C : (a ^ 8'hA5);
    endfunction

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            waitCnt <= 4'h0;
            served <= 1'b0;
            romAck <= 1'b0;
            romData <= 8'h00;
        end
        else
        begin
            romAck <= 1'b0;
            romData <= ~romData;
            if (!romReq.req)
            begin
                waitCnt <= 4'h0;
                served <= 1'b0;
            end
            else if (!served && waitCnt >= (slow ? 4'h6 : 4'h1))
            begin
                romAck <= 1'b1;
                romData <= romByte(romReq.addr);
                served <= 1'b1;
            end
            else if (!served)
                waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule // eeprom_reader_model

// >>> testbench/tb_link_eeprom_retry_regs.sv
//
// Purpose: Self-checking bench for the link EEPROM and retry register group
// Assumes: EEPROM strap present until the final strap-low reset in t_no_rom; reader model answers requests
// Notes: Expected bytes follow the model contents
//
`timescale 1ns/100ps
module tb_link_eeprom_retry_regs;
    import link_regs_pkg::*;
    logic clk, resetn, regWrStrobe, regRdStrobe, eepromDetect, swapValueLoad, romAck, slow;
    logic idEepromPresent, busInfoLoadStart, smallRomValid;
    logic [7:0] regAddr, romData;
    logic [31:0] regWrData, regRdData, swapValueIn, d;
    rom_req_t romReq;
    tx_attempt_t att [3];
    tx_result_t res [3];
    int error_cnt = 0;
    int n_checks = 0;

    link_eeprom_retry_regs i_dut (.clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
        .regRdData(regRdData), .eepromDetect(eepromDetect), .romReq(romReq), .romAck(romAck),
        .romData(romData), .idEepromPresent(idEepromPresent),
        .busInfoLoadStart(busInfoLoadStart), .smallRomValid(smallRomValid),
        .swapValueLoad(swapValueLoad), .swapValueIn(swapValueIn), .physRespAttempt(att[2]),
        .txRespAttempt(att[1]), .txReqAttempt(att[0]), .physRespResult(res[2]),
        .txRespResult(res[1]), .txReqResult(res[0]));
    eeprom_reader_model i_mem (.clk(clk), .resetn(resetn), .slow(slow), .romReq(romReq),
        .romAck(romAck), .romData(romData));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic end_of_test;
        if (error_cnt == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", name, e, g);
            error_cnt++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regWrData <= v;
        regWrStrobe <= 1'b1;
        @(posedge clk);
        regWrStrobe <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge clk);
        regRdStrobe <= 1'b0;
        #1;
        d = regRdData;
    endtask

    // Bounded wait for a self-clearing bit; a hung bit shows as a mismatch
    task automatic poll(input int b, input logic [7:0] e);
        int k;
        k = 0;
        rd(ADDR_ROM_ACCESS);
        while (d[b] !== 1'b0 && k < 40)
        begin
            rd(ADDR_ROM_ACCESS);
            k++;
        end
        chk("self clear bits", 32'h0, d & 32'h8200_0000);
        chk("read byte", {24'h0, e}, {24'h0, d[23:16]});
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_boot;
        chk("present flag", 32'h1, {31'h0, idEepromPresent});
        chk("small rom valid", 32'h1, {31'h0, smallRomValid});
        rd(ADDR_ROM_ACCESS);
        chk("access after boot", 32'h0000_004C, d & 32'hFF00_FFFF);
        rd(ADDR_RETRY_LIMITS);
        chk("retry reset", 32'h0, d);
    endtask

    task automatic t_regs;
        wr(ADDR_RETRY_LIMITS, 32'hFFFF_FFFF);
        rd(ADDR_RETRY_LIMITS);
        chk("retry fields", 32'h0000_0FFF, d);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10);
        chk("unmapped", 32'h0, d);
        wr(ADDR_ROM_ACCESS, 32'h7CFF_FFFF);
        rd(ADDR_ROM_ACCESS);
        chk("read-only fields", 32'h0000_004C, d & 32'hFF00_FFFF);
        @(posedge clk);
        swapValueLoad <= 1'b1;
        swapValueIn <= 32'hC0DE_1234;
        @(posedge clk);
        swapValueLoad <= 1'b0;
        wr(ADDR_SWAP_STORE, 32'h0);
        rd(ADDR_SWAP_STORE);
        chk("swap store", 32'hC0DE_1234, d);
    endtask

    task automatic t_rom;
        if (idEepromPresent === 1'b1)
        begin
            wr(ADDR_ROM_ACCESS, 32'h8200_0000);
            poll(25, 8'hA5);
            wr(ADDR_ROM_ACCESS, 32'h8000_0000);
            poll(31, 8'hA5);
            @(posedge clk);
            slow <= 1'b1;
            wr(ADDR_ROM_ACCESS, 32'h0200_0000);
            poll(25, 8'hA5);
            @(posedge clk);
            slow <= 1'b0;
            wr(ADDR_ROM_ACCESS, 32'h0200_0000);
            poll(25, 8'hA4);
        end
    endtask

    // Unit 0 request, 1 response, 2 physical response
    task automatic t_retry(input int u, input logic [3:0] lim, input ack_code_t a);
        int n;
        n = (a == ACK_DONE) ? 0 : int'(lim);
        wr(ADDR_RETRY_LIMITS, 32'(lim) << (4 * u));
        @(posedge clk);
        att[u].start <= 1'b1;
        @(posedge clk);
        att[u].start <= 1'b0;
        for (int k = 0; k <= n; k++)
        begin
            repeat (2) @(posedge clk);
            att[u].ack <= a;
            att[u].ackValid <= 1'b1;
            @(posedge clk);
            att[u].ackValid <= 1'b0;
            #1;
            chk("retry or finish", {30'h0, k < n, k == n},
                {30'h0, res[u].retry, res[u].finished});
            if (k == n)
                chk("final ack", {30'h0, a}, {30'h0, res[u].finalAck});
        end
    endtask

    // Second reset with the strap low: no boot fetch, offset keeps its reset value
    task automatic t_no_rom;
        @(posedge clk);
        resetn <= 1'b0;
        eepromDetect <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk("absent flag", 32'h0, {31'h0, idEepromPresent});
        chk("no small rom", 32'h0, {31'h0, smallRomValid});
        chk("no boot fetch", 32'h0, {31'h0, romReq.req});
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_of_test;
    end

    initial
    begin
        {resetn, regWrStrobe, regRdStrobe, swapValueLoad, slow} = 5'h00;
        eepromDetect = 1'b1;
        regAddr = 8'h00;
        regWrData = 32'h0;
        swapValueIn = 32'h0;
        att = '{default: '0};
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (20) @(posedge clk);
        t_boot;
        t_regs;
        t_rom;
        t_retry(0, 4'h0, ACK_BUSY);
        t_retry(0, 4'h3, ACK_DATA_ERR);
        t_retry(1, 4'h2, ACK_BUSY);
        t_retry(2, 4'hF, ACK_DATA_ERR);
        t_retry(2, 4'h1, ACK_DONE);
        t_no_rom;
        end_of_test;
    end
endmodule // tb_link_eeprom_retry_regs
